// File: hw/qfac_top.sv
/*
 * qfac_top: encoder feedback, scaling and coupling of four motors.
 * Registers sit on AXI4-Lite.
 * Assumes the motor loops outside
 * supply currents and setpoints
 * and take back coupled values.
 */
//
// Contract
// [RQ1] resolutions 10, 5, 2.5, 1.25 um scale positions by 2, 4, 8, 16.
// [RQ2] incoming positions are scaled, speed and accel are not.
// [RQ3] the encoder head sends A and B 90 degrees apart.
// [RQ4] decoding is 1x, 2x or 4x.
// [RQ5] a motor's source setting picks link 1 or 2 and decode mode; here only the lowest motor selecting a link sets that link's decode mode.
// [RQ6] any encoder link can feed any motor.
// [RQ7] a booster axis has one master and at most three boosters.
// [RQ8] boosters take the master's current command.
// [RQ9] a reverse booster negates that current.
// [RQ10] gantry slaves copy the master's setpoint and close own loops.
// [RQ11] at most three gantry slaves follow one gantry master.
// [RQ12] software sets up a master before its followers.
// [RQ13] gantry motors may take actual position from external sensors.
// [RQ14] A and B are synchronised, lead gives direction, edges counted per mode.
// [RQ15] at 20 um the factor is 1.
`timescale 1ns/1ps
`default_nettype none
module qfac_top #(
    parameter int NUM_MOTORS = qfac_pkg::NUM_MOTORS,
    parameter int NUM_LINKS  = qfac_pkg::NUM_LINKS,
    parameter int POS_W      = qfac_pkg::POS_W,
    parameter int CUR_W      = qfac_pkg::CUR_W
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // encoder links
    input  wire qfac_pkg::qfac_ab_type [NUM_LINKS-1:0] enc_ab,
    // per-motor loop interface
    input  wire logic [NUM_MOTORS*CUR_W-1:0] loop_current,
    input  wire logic [NUM_MOTORS*POS_W-1:0] loop_setpoint,
    output logic [NUM_MOTORS*CUR_W-1:0]      drive_current,
    output logic [NUM_MOTORS*POS_W-1:0]      drive_setpoint,
    output logic [NUM_MOTORS*POS_W-1:0]      actual_pos,
    output logic [NUM_MOTORS-1:0]            loop_enable,
    output logic                             config_error
);

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [31:0]               src_sel;
    logic [31:0]               couple;
    qfac_pkg::qfac_res_type    res_sel;
    logic [NUM_LINKS-1:0]      link_clear;
    logic [31:0]               scale_in;
    logic [31:0]               scale_q;
    logic signed [POS_W-1:0]   link_pos [NUM_LINKS];

    // scale input value by kind [RQ2]
    function automatic logic [31:0] scale_value(input logic [31:0] word,
                                                input qfac_pkg::qfac_res_type res);
        logic signed [29:0] val;
        val = word[31:2];
        if (qfac_pkg::qfac_kind_type'(word[1:0]) == qfac_pkg::KIND_POSITION) begin
            val = val <<< res;                                       // [RQ1] [RQ15]
        end
        return {val, word[1:0]};                                     // [RQ2]
    endfunction : scale_value

    ////////////////////////////////////////////////////////////////////////////
    // encoder decoders, one per link
    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
        // lowest motor selecting a link sets its mode
        qfac_pkg::qfac_decode_type link_mode;
        always_comb begin
            link_mode = qfac_pkg::DEC_QUAD;
            for (int m = NUM_MOTORS - 1; m >= 0; m--) begin
                if (src_sel[m*qfac_pkg::SRC_FIELD_W + qfac_pkg::SRC_LINK_BIT] == 1'(l)) begin
                    link_mode = qfac_pkg::qfac_decode_type'(
                        src_sel[m*qfac_pkg::SRC_FIELD_W +: 2]);      // [RQ5]
                end
            end
        end
        qfac_decoder #(
            .POS_W (POS_W)
        ) u_dec (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ab_in   (enc_ab[l]),                                    // [RQ3]
            .mode    (link_mode),
            .clear   (link_clear[l]),
            .count   (link_pos[l])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // coupling per motor
    function automatic qfac_pkg::qfac_couple_type cpl(input logic [31:0] c, input int m);
        return qfac_pkg::qfac_couple_type'(c[m*8 +: 5]);
    endfunction : cpl

    // invalid follower references
    logic [NUM_MOTORS-1:0] bad_ref;
    always_comb begin
        bad_ref = '0;
        for (int m = 0; m < NUM_MOTORS; m++) begin
            if (cpl(couple, m).role inside {qfac_pkg::ROLE_BOOSTER, qfac_pkg::ROLE_GANTRY}) begin
                // follower names another, configured master [RQ12]
                if (cpl(couple, m).master == m[1:0] ||
                    cpl(couple, int'(cpl(couple, m).master)).role != qfac_pkg::ROLE_MASTER) begin
                    bad_ref[m] = 1'b1;
                end
            end
        end
    end
    // four motors: one master, three followers at most [RQ7] [RQ11]
    wire cfg_bad = |bad_ref;

    logic [NUM_MOTORS*CUR_W-1:0] next_current;
    logic [NUM_MOTORS*POS_W-1:0] next_setpoint;
    logic [NUM_MOTORS*POS_W-1:0] next_actual;
    logic [NUM_MOTORS-1:0]       next_enable;
    always_comb begin
        next_current  = loop_current;
        next_setpoint = loop_setpoint;
        next_enable   = '1;
        next_actual   = '0;
        for (int m = 0; m < NUM_MOTORS; m++) begin
            // any link to any motor [RQ6] [RQ13]
            next_actual[m*POS_W +: POS_W] = link_pos[
                src_sel[m*qfac_pkg::SRC_FIELD_W + qfac_pkg::SRC_LINK_BIT]];
            if (!bad_ref[m]) begin
                if (cpl(couple, m).role == qfac_pkg::ROLE_BOOSTER) begin
                    next_enable[m] = 1'b0;                           // [RQ8]
                    next_current[m*CUR_W +: CUR_W] = cpl(couple, m).reverse ?
                        CUR_W'(-$signed(loop_current[cpl(couple, m).master*CUR_W +: CUR_W])) :
                        loop_current[cpl(couple, m).master*CUR_W +: CUR_W];   // [RQ9]
                end else if (cpl(couple, m).role == qfac_pkg::ROLE_GANTRY) begin
                    next_setpoint[m*POS_W +: POS_W] =
                        loop_setpoint[cpl(couple, m).master*POS_W +: POS_W];  // [RQ10]
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_current  <= '0;
            drive_setpoint <= '0;
            actual_pos     <= '0;
            loop_enable    <= '0;
            config_error   <= 1'b0;
        end else begin
            drive_current  <= next_current;
            drive_setpoint <= next_setpoint;
            actual_pos     <= next_actual;
            loop_enable    <= next_enable;
            config_error   <= cfg_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: aw and w in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire do_wr   = aw_held & w_held & ~s_axi_bvalid;

    wire sel_src   = aw_addr == qfac_pkg::OFS_SRC_SEL;
    wire sel_cpl   = aw_addr == qfac_pkg::OFS_COUPLE;
    wire sel_res   = aw_addr == qfac_pkg::OFS_RES_SEL;
    wire sel_clr   = aw_addr == qfac_pkg::OFS_CLEAR;
    wire sel_scale = aw_addr == qfac_pkg::OFS_SCALE_IN;
    wire wr_ok     = sel_src | sel_cpl | sel_res | sel_clr | sel_scale;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                old[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return old;
    endfunction : merge

    wire [31:0] src_merged = merge(src_sel, w_data, w_strb);
    wire [31:0] cpl_merged = merge(couple, w_data, w_strb);
    wire [31:0] scl_merged = merge(scale_in, w_data, w_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_wr) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= qfac_pkg::AXI_OKAY;
            src_sel       <= qfac_pkg::SRC_SEL_RESET;
            couple        <= qfac_pkg::COUPLE_RESET;
            res_sel       <= qfac_pkg::qfac_res_type'(qfac_pkg::RES_RESET);
            link_clear    <= '0;
            scale_in      <= '0;
            scale_q       <= '0;
        end else begin
            s_axi_awready <= ~aw_held & ~aw_take;
            s_axi_wready  <= ~w_held & ~w_take;
            link_clear    <= '0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? qfac_pkg::AXI_OKAY : qfac_pkg::AXI_SLVERR;
                if (sel_src) begin
                    src_sel <= src_merged;
                end else if (sel_cpl) begin
                    couple <= cpl_merged;
                end else if (sel_res && w_strb[0]) begin
                    // unknown codes keep the old value
                    if (w_data[2:0] <= 3'(qfac_pkg::RES_1U25M)) begin
                        res_sel <= qfac_pkg::qfac_res_type'(w_data[2:0]);
                    end
                end else if (sel_clr && w_strb[0]) begin
                    link_clear <= w_data[NUM_LINKS-1:0];
                end else if (sel_scale) begin
                    scale_in <= scl_merged;
                    scale_q  <= scale_value(scl_merged, res_sel);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read: answer one cycle after the address
    wire [7:0] ra = s_axi_araddr;
    wire [1:0] ri = ra[3:2];
    wire [31:0] rd_value =
        (ra == qfac_pkg::OFS_SRC_SEL)  ? src_sel :
        (ra == qfac_pkg::OFS_COUPLE)   ? couple :
        (ra == qfac_pkg::OFS_RES_SEL)  ? {29'h0, res_sel} :
        (ra == qfac_pkg::OFS_CLEAR)    ? 32'h0000_0000 :
        (ra == qfac_pkg::OFS_SCALE_IN) ? scale_in :
        (ra == qfac_pkg::OFS_SCALE_Q)  ? scale_q :
        (ra[7:4] == qfac_pkg::OFS_LINK_POS[7:4] && ri < 2'(NUM_LINKS)) ?
            32'(link_pos[ri[0]]) :
        (ra[7:4] == qfac_pkg::OFS_MOT_POS[7:4]) ? 32'(actual_pos[ri*POS_W +: POS_W]) :
        (ra[7:4] == qfac_pkg::OFS_SETPT[7:4])   ? 32'(drive_setpoint[ri*POS_W +: POS_W]) :
        32'h0000_0000;
    wire rd_ok = (ra <= qfac_pkg::OFS_SCALE_Q) ||
                 (ra[7:4] == qfac_pkg::OFS_LINK_POS[7:4] && ri < 2'(NUM_LINKS)) ||
                 ra[7:4] == qfac_pkg::OFS_MOT_POS[7:4] ||
                 ra[7:4] == qfac_pkg::OFS_SETPT[7:4];
    wire ar_take = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= qfac_pkg::AXI_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_value : 32'h0000_0000;
                s_axi_rresp  <= rd_ok ? qfac_pkg::AXI_OKAY : qfac_pkg::AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : qfac_top
`default_nettype wire

// File: include/qfac_pkg.sv
/*
 * qfac_pkg: constants and types of the feedback and coupling block.
 * Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
 */
package qfac_pkg;

    localparam int NUM_MOTORS = 4;
    localparam int NUM_LINKS  = 2;
    localparam int POS_W      = 32;
    localparam int CUR_W      = 16;

    // register byte offsets
    localparam logic [7:0] OFS_SRC_SEL  = 8'h00;
    localparam logic [7:0] OFS_COUPLE   = 8'h04;
    localparam logic [7:0] OFS_RES_SEL  = 8'h08;
    localparam logic [7:0] OFS_CLEAR    = 8'h0C;
    localparam logic [7:0] OFS_SCALE_IN = 8'h10;
    localparam logic [7:0] OFS_SCALE_Q  = 8'h14;
    localparam logic [7:0] OFS_LINK_POS = 8'h20;
    localparam logic [7:0] OFS_MOT_POS  = 8'h30;
    localparam logic [7:0] OFS_SETPT    = 8'h40;

    // source field per motor: link bit 2, decode bits 1:0
    localparam int SRC_FIELD_W = 4;
    localparam int SRC_LINK_BIT = 2;
    // coupling byte per motor: reverse bit 2
    localparam int CPL_FIELD_W = 4;
    localparam int CPL_REV_BIT = 2;
    // reset values
    localparam logic [31:0] SRC_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] COUPLE_RESET  = 32'h0000_0000;
    localparam logic [2:0]  RES_RESET     = 3'h0;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DEC_SINGLE,
        DEC_DOUBLE,
        DEC_QUAD,
        DEC_RSVD
    } qfac_decode_type;

    // source codes: link_one_single_decode .. link_two_quad_decode
    typedef enum logic [2:0] {
        link_one_single_decode = 3'h0,
        link_one_double_decode = 3'h1,
        link_one_quad_decode   = 3'h2,
        link_two_single_decode = 3'h4,
        link_two_double_decode = 3'h5,
        link_two_quad_decode   = 3'h6
    } qfac_source_type;

    typedef enum logic [1:0] {
        ROLE_SINGLE,
        ROLE_MASTER,
        ROLE_BOOSTER,
        ROLE_GANTRY
    } qfac_role_type;

    // resolution codes: 20, 10, 5, 2.5, 1.25 um -> shift 0..4
    typedef enum logic [2:0] {
        RES_20UM,
        RES_10UM,
        RES_5UM,
        RES_2U5M,
        RES_1U25M
    } qfac_res_type;

    typedef enum logic [1:0] {
        KIND_POSITION,
        KIND_SPEED,
        KIND_ACCEL,
        KIND_RSVD
    } qfac_kind_type;

    typedef struct packed {
        logic a;
        logic b;
    } qfac_ab_type;

    typedef struct packed {
        qfac_role_type role;
        logic          reverse;
        logic [1:0]    master;
    } qfac_couple_type;

endpackage : qfac_pkg

// File: hw/qfac_decoder.sv
/*
 * qfac_decoder: one A/B quadrature channel to a signed position count.
 * Assumes A and B arrive asynchronous to aclk; they are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module qfac_decoder #(
    parameter int POS_W = 32
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire qfac_pkg::qfac_ab_type    ab_in,
    input  wire qfac_pkg::qfac_decode_type mode,
    input  wire logic                     clear,
    output logic signed [POS_W-1:0]       count
);

    qfac_pkg::qfac_ab_type sync_a;
    qfac_pkg::qfac_ab_type sync_b;
    qfac_pkg::qfac_ab_type prev;

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, then an edge history stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= '0;
            sync_b <= '0;
            prev   <= '0;
        end else begin
            sync_a <= ab_in;   // [RQ14]
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    wire edge_a  = sync_b.a ^ prev.a;
    wire edge_b  = sync_b.b ^ prev.b;
    // a leads b: forward
    wire dir_a   = sync_b.a ^ prev.b;
    wire dir_b   = ~(sync_b.b ^ prev.a);
    wire bad     = edge_a & edge_b;   // both moved: direction unknown, skip
    wire step_q  = (edge_a | edge_b) & ~bad;
    wire up_q    = edge_a ? dir_a : dir_b;
    // single decode counts only the rising edge of a
    wire step_1  = edge_a & sync_b.a & ~bad;
    wire step_2  = edge_a & ~bad;

    wire step = (mode == qfac_pkg::DEC_QUAD)   ? step_q :                          // [RQ4]
                (mode == qfac_pkg::DEC_DOUBLE) ? step_2 :
                (mode == qfac_pkg::DEC_SINGLE) ? step_1 : 1'b0;                   // [RQ14]
    wire up   = (mode == qfac_pkg::DEC_QUAD) ? up_q : dir_a;

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= '0;
        end else if (step) begin
            count <= up ? count + POS_W'(1) : count - POS_W'(1);
        end
    end

endmodule : qfac_decoder
`default_nettype wire

// File: tb/qfac_enc_model.sv
/*
 * qfac_enc_model: behavioural encoder head, one quarter step per step pulse.
 * Assumes steps spaced wider than the decoder's synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module qfac_enc_model (
    input  wire logic             step,
    input  wire logic             dir,
    output qfac_pkg::qfac_ab_type ab
);
    logic [1:0] ph = 2'h0;
    always @(posedge step) begin
        ph <= dir ? ph + 2'h1 : ph - 2'h1;
    end
    // gray code: a leads b while dir is high
    assign ab = {ph[0] ^ ph[1], ph[1]};
endmodule : qfac_enc_model
`default_nettype wire

// File: tb/qfac_assertions.sv
/*
 * qfac_assertions: port-level checks on qfac_top.
 * Assumes it is bound into every qfac_top instance.
 */
`timescale 1ns/1ps
`default_nettype none
module qfac_assertions #(
    parameter int NUM_MOTORS = 4,
    parameter int NUM_LINKS  = 2,
    parameter int POS_W      = 32,
    parameter int CUR_W      = 16
) (
    input wire logic                                  aclk,
    input wire logic                                  aresetn,
    input wire logic                                  s_axi_awvalid,
    input wire logic                                  s_axi_awready,
    input wire logic                                  s_axi_wvalid,
    input wire logic                                  s_axi_wready,
    input wire logic [1:0]                            s_axi_bresp,
    input wire logic                                  s_axi_bvalid,
    input wire logic                                  s_axi_bready,
    input wire logic                                  s_axi_arvalid,
    input wire logic                                  s_axi_arready,
    input wire logic [31:0]                           s_axi_rdata,
    input wire logic [1:0]                            s_axi_rresp,
    input wire logic                                  s_axi_rvalid,
    input wire logic                                  s_axi_rready,
    input wire qfac_pkg::qfac_ab_type [NUM_LINKS-1:0] enc_ab,
    input wire logic [NUM_MOTORS*CUR_W-1:0]           drive_current,
    input wire logic [NUM_MOTORS*POS_W-1:0]           actual_pos,
    input wire logic [NUM_MOTORS-1:0]                 loop_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    function automatic logic [CUR_W-1:0] cur(input int i);
        return drive_current[i*CUR_W +: CUR_W];
    endfunction : cur
    // a loopless motor carries an enabled motor's current or its negation
    logic [NUM_MOTORS-1:0] share_ok;
    always_comb begin
        share_ok = '0;
        for (int m = 0; m < NUM_MOTORS; m++)
            for (int j = 0; j < NUM_MOTORS; j++)
                if (loop_enable[j] && (cur(m) == cur(j) || cur(m) == -cur(j)))
                    share_ok[m] = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped early");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        !s_axi_bvalid && !s_axi_rvalid && loop_enable == '0) else $error("active in reset");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_pos_still: assert property (($stable(enc_ab) && !s_axi_wvalid)[*6] |=>
        $stable(actual_pos)) else $error("position moved without encoder edge");
    for (genvar g = 0; g < NUM_MOTORS; g++) begin : g_share
        a_boost_share: assert property (!loop_enable[g] && |loop_enable |->
            share_ok[g]) else $error("booster current not shared");
    end
endmodule : qfac_assertions
bind qfac_top qfac_assertions #(.NUM_MOTORS(NUM_MOTORS), .NUM_LINKS(NUM_LINKS),
    .POS_W(POS_W), .CUR_W(CUR_W)) chk (.*);
`default_nettype wire

// File: tb/testbench.sv
/*
 * testbench: self-checking bench for qfac_top with two encoder heads.
 * Assumes the checker is bound in; reads are scored from a queue.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic         aclk, aresetn, config_error, s_axi_awvalid, s_axi_awready;
    logic         s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic [3:0]   s_axi_wstrb, loop_enable;
    logic [1:0]   s_axi_bresp, s_axi_rresp, stp, dir;
    logic [63:0]  loop_current, drive_current;
    logic [127:0] loop_setpoint, drive_setpoint, actual_pos;
    qfac_pkg::qfac_ab_type [1:0] enc_ab;
    logic [33:0]  exq[$];
    int           n_errors, samples_checked, seed, v;
    qfac_top dut (.*);
    qfac_enc_model enc0 (.step(stp[0]), .dir(dir[0]), .ab(enc_ab[0]));
    qfac_enc_model enc1 (.step(stp[1]), .dir(dir[1]), .ab(enc_ab[1]));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tick(inout int n);
        n++;
        if (n > 200) begin
            n_errors++;
            end_sim;
        end
    endtask : tick
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int   n;
        logic pa, pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
            tick(n);
        end while (pa || pw);
        do begin @(negedge aclk); tick(n); end while (!s_axi_bvalid);
        check(s_axi_bresp, r);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        exq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin @(negedge aclk); tick(n); end while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); tick(n); end while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // steps spread wide: one encoder edge per eight clocks
    task automatic stepn(input int l, input logic d, input int k);
        repeat (k) begin
            @(posedge aclk);
            dir[l] <= d;
            stp[l] <= 1'b1;
            @(posedge aclk);
            stp[l] <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask : stepn
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exq.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h1138;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, stp, dir} = '0;
        {loop_current, loop_setpoint} = '0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_rd(8'h00, 32'h0000_0000, 2'h0);
        axi_rd(8'h04, 32'h0000_0000, 2'h0);
        axi_rd(8'hFC, 32'h0000_0000, 2'h2);
        axi_wr(8'hFC, 32'h0000_0001, 2'h2);
        axi_wr(8'h20, 32'h0000_0001, 2'h2);
        // motor 0 sets link one's decode mode
        for (int m = 0; m < 3; m++) begin
            axi_wr(8'h00, 32'h0000_4150 | m, 2'h0);
            axi_wr(8'h0C, 32'h0000_0001, 2'h0);
            stepn(0, 1'b1, 16);
            stepn(0, 1'b0, 8);
            axi_rd(8'h20, 32'd8 >> (2 - m), 2'h0);
            axi_rd(8'h38, 32'd8 >> (2 - m), 2'h0);
        end
        stepn(1, 1'b0, 12);
        axi_rd(8'h24, 32'hFFFF_FFFA, 2'h0);
        axi_rd(8'h34, 32'hFFFF_FFFA, 2'h0);
        axi_rd(8'h3C, 32'hFFFF_FFFA, 2'h0);
        for (int r = 0; r < 6; r++) begin
            v = $random(seed) % 65536;
            axi_wr(8'h08, r, 2'h0);
            for (int k = 0; k < 3; k++) begin
                axi_wr(8'h10, (v << 2) | k, 2'h0);
                axi_rd(8'h14, ((k ? v : v << (r > 4 ? 4 : r)) << 2) | k, 2'h0);
            end
        end
        axi_wr(8'h04, 32'h1814_1008, 2'h0);
        repeat (3) begin
            @(posedge aclk);
            loop_current  <= {$random(seed), $random(seed)};
            loop_setpoint <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            check(drive_current[15:0], loop_current[15:0]);
            check(drive_current[31:16], loop_current[15:0]);
            check(drive_current[47:32], 16'(-loop_current[15:0]));
            check(drive_current[63:48], loop_current[63:48]);
            check(loop_enable, 4'b1001);
            axi_rd(8'h4C, loop_setpoint[31:0], 2'h0);
        end
        axi_wr(8'h04, 32'h1814_1109, 2'h0);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        check(config_error, 1'b1);
        check(drive_current[31:16], loop_current[31:16]);
        axi_rd(8'h04, 32'h1814_1109, 2'h0);
        end_sim;
    end
endmodule : testbench
`default_nettype wire
